// ===== rft_cfg.svh
// offsets, field positions, reset and trim values for the receive fifo threshold register
`ifndef RFT_CFG_SVH
`define RFT_CFG_SVH

// configuration address space positions (6-bit address)
`define RFT_ADDR_CTL 6'h03
`define RFT_ADDR_TRIM_A 6'h2D
`define RFT_ADDR_TRIM_B 6'h2C

// control register reset value and field positions
`define RFT_CTL_RESET 8'h07
`define RFT_KEEP_BIT 6
`define RFT_ATT_HI 5
`define RFT_ATT_LO 4
`define RFT_LVL_HI 3
`define RFT_LVL_LO 0

// trim values pushed into the analog section on wake
`define RFT_TRIM_A_DROP 8'h31
`define RFT_TRIM_B_DROP 8'h88
`define RFT_TRIM_A_KEEP 8'h35
`define RFT_TRIM_B_KEEP 8'h81

// trigger level: bytes = level * 4 + 4
`define RFT_LVL_BASE 7'h04
`define RFT_FIFO_DEPTH 7'h40

`endif

// ===== rft_pkg.sv
// types shared by the receive fifo threshold register and its level logic
package rft_pkg;

    typedef logic [7:0] rft_byte_t;
    typedef logic [5:0] rft_addr_t;
    typedef logic [6:0] rft_count_t;

    // control register layout, msb first
    typedef struct packed {
        logic spare;
        logic wake_trim_keep;
        logic [1:0] rx_atten_sel;
        logic [3:0] rx_fill_trigger_level;
    } rft_fields_t;

    // power state as seen by the trim logic
    typedef enum logic [0:0] {
        RFT_AWAKE,
        RFT_ASLEEP
    } rft_pwr_t;

endpackage

// ===== rft_fld_if.sv
// carrier between the control register and the fill level logic
`timescale 1ns/1ps
`default_nettype none

interface rft_fld_if;
    logic [3:0] level;
    logic [1:0] atten;
    logic [6:0] fill_count;
    logic over;
    logic [4:0] atten_db;

    modport ctl (output level, output atten, output fill_count, input over, input atten_db);
    modport lvl (input level, input atten, input fill_count, output over, output atten_db);
endinterface

`default_nettype wire

// ===== rft_level.sv
// fill level compare and attenuation decode for the receive fifo threshold block
`timescale 1ns/1ps
`default_nettype none
`include "rft_cfg.svh"

module rft_level (
    input wire logic ref_clk_i,   // 10 MHz clock
    input wire logic resetn_i,    // async reset, active low
    rft_fld_if.lvl fld            // fields in, results out
);
    import rft_pkg::*;

    logic [6:0] trigger_bytes;
    logic [4:0] atten_db_next;
    logic over_next;
    logic over_reg;
    logic [4:0] atten_db_reg;

    // trigger bytes from the level field, 4 at 0 up to 64 at 15
    assign trigger_bytes = {1'b0, fld.level, 2'b00} + `RFT_LVL_BASE;
    assign over_next = (fld.fill_count >= trigger_bytes);
    // 6 dB per step, built from shifts so no multiplier is inferred
    assign atten_db_next = {1'b0, fld.atten, 2'b00} + {2'b00, fld.atten, 1'b0};

    // registered so the top sees flop outputs
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            over_reg <= 1'b0;
            atten_db_reg <= 5'h00;
        end else begin
            over_reg <= over_next;
            atten_db_reg <= atten_db_next;
        end
    end

    assign fld.over = over_reg;
    assign fld.atten_db = atten_db_reg;

    AST_FILL_FULL: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (fld.level == 4'hF && fld.fill_count == `RFT_FIFO_DEPTH) |=> fld.over)
        else $error("full fifo at top level not flagged");

    AST_FILL_EDGE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (fld.fill_count == trigger_bytes - 7'h01) ##1 (fld.fill_count == $past(trigger_bytes)
            && fld.level == $past(fld.level)) |-> !fld.over ##1 fld.over)
        else $error("threshold not met exactly at equal count");

    AST_ATTEN_DB: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (fld.atten == 2'h3) |=> (fld.atten_db == 5'h12))
        else $error("top attenuation step not 18 dB");

endmodule

`default_nettype wire

// ===== rft_top.sv
// receive fifo threshold control register with wake trim selection
`timescale 1ns/1ps
`default_nettype none
`include "rft_cfg.svh"


module rft_top #(
    parameter rft_pkg::rft_byte_t TRIM_A_RESET = 8'h00,  // trim a readback value
    parameter rft_pkg::rft_byte_t TRIM_B_RESET = 8'h00   // trim b readback value
) (
    input wire logic ref_clk_i,                       // 10 MHz clock
    input wire logic resetn_i,                        // async reset, active low
    input wire rft_pkg::rft_addr_t cfg_addr_i,        // config address
    input wire logic cfg_wr_i,                        // write strobe
    input wire rft_pkg::rft_byte_t cfg_wdata_i,       // write data
    input wire logic cfg_rd_i,                        // read strobe
    output rft_pkg::rft_byte_t cfg_rdata_o,           // read data, next cycle
    input wire logic sleep_enter_i,                   // enter sleep pulse
    input wire logic wake_i,                          // wake pulse
    output logic asleep_o,                            // sleep state
    output rft_pkg::rft_byte_t analog_trim_a_o,       // analog trim a
    output rft_pkg::rft_byte_t analog_trim_b_o,       // analog trim b
    output logic [1:0] rx_atten_sel_o,                // attenuation select
    output logic [4:0] rx_atten_db_o,                 // attenuation in dB
    input wire rft_pkg::rft_count_t rx_fill_count_i,  // fifo byte count
    output logic rx_fill_over_o                       // threshold reached
);
    import rft_pkg::*;

    rft_byte_t ctl_reg;
    rft_byte_t ctl_next;
    rft_fields_t fields;
    rft_byte_t rdata_reg;
    rft_byte_t rdata_next;
    rft_pwr_t pwr_reg;
    rft_pwr_t pwr_next;
    rft_byte_t trim_a_reg;
    rft_byte_t trim_b_reg;
    rft_byte_t trim_a_next;
    rft_byte_t trim_b_next;
    logic [1:0] atten_reg;
    logic hit_ctl;
    logic hit_trim_a;
    logic hit_trim_b;
    logic wake_event;

    rft_fld_if fld ();

    // address decode
    assign hit_ctl = (cfg_addr_i == `RFT_ADDR_CTL);
    assign hit_trim_a = (cfg_addr_i == `RFT_ADDR_TRIM_A);
    assign hit_trim_b = (cfg_addr_i == `RFT_ADDR_TRIM_B);

    // all eight bits are kept, including the spare top bit
    assign ctl_next = (cfg_wr_i && hit_ctl) ? cfg_wdata_i : ctl_reg;
    assign fields = rft_fields_t'(ctl_reg);

    // control register
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_reg <= `RFT_CTL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // readback; trim offsets answer with reset values, never the wake values
    assign rdata_next = !cfg_rd_i ? rdata_reg :
                        hit_ctl ? ctl_reg :
                        hit_trim_a ? TRIM_A_RESET :
                        hit_trim_b ? TRIM_B_RESET :
                        8'h00;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // power state: a wake only counts when coming out of sleep
    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            RFT_AWAKE: begin
                if (sleep_enter_i) begin
                    pwr_next = RFT_ASLEEP;
                end
            end
            RFT_ASLEEP: begin
                if (wake_i) begin
                    pwr_next = RFT_AWAKE;
                end
            end
        endcase
    end

    assign wake_event = (pwr_reg == RFT_ASLEEP) && wake_i;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwr_reg <= RFT_AWAKE;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    // trim choice is sampled from the keep bit in the wake cycle itself
    assign trim_a_next = !wake_event ? trim_a_reg :
                         fields.wake_trim_keep ? `RFT_TRIM_A_KEEP :
                         `RFT_TRIM_A_DROP;
    assign trim_b_next = !wake_event ? trim_b_reg :
                         fields.wake_trim_keep ? `RFT_TRIM_B_KEEP :
                         `RFT_TRIM_B_DROP;

    // analog-only trim copies; they start at the readback reset values
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trim_a_reg <= TRIM_A_RESET;
            trim_b_reg <= TRIM_B_RESET;
        end else begin
            trim_a_reg <= trim_a_next;
            trim_b_reg <= trim_b_next;
        end
    end

    // attenuation select copy, one cycle behind the register
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            atten_reg <= 2'h0;
        end else begin
            atten_reg <= fields.rx_atten_sel;
        end
    end

    // fields to the level logic
    assign fld.level = fields.rx_fill_trigger_level;
    assign fld.atten = fields.rx_atten_sel;
    assign fld.fill_count = rx_fill_count_i;

    rft_level u_level (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .fld(fld)
    );

    // outputs, each from a flop here or in the level logic
    assign cfg_rdata_o = rdata_reg;
    assign asleep_o = (pwr_reg == RFT_ASLEEP);
    assign analog_trim_a_o = trim_a_reg;
    assign analog_trim_b_o = trim_b_reg;
    assign rx_atten_sel_o = atten_reg;
    assign rx_atten_db_o = fld.atten_db;
    assign rx_fill_over_o = fld.over;

    AST_TRIM_DROP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (asleep_o && wake_i && !ctl_reg[`RFT_KEEP_BIT])
            |=> (analog_trim_a_o == 8'h31 && analog_trim_b_o == 8'h88 && !asleep_o))
        else $error("wake without keep gave wrong trims");

    AST_TRIM_KEEP: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (asleep_o && wake_i && ctl_reg[`RFT_KEEP_BIT])
            |=> (analog_trim_a_o == 8'h35 && analog_trim_b_o == 8'h81 && !asleep_o))
        else $error("wake with keep gave wrong trims");

    AST_TRIM_READ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (cfg_rd_i && (hit_trim_a || hit_trim_b))
            |=> (cfg_rdata_o == ($past(hit_trim_a) ? TRIM_A_RESET : TRIM_B_RESET)))
        else $error("trim readback not reset value");

    AST_RESET_VAL: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> (ctl_reg == 8'h07))
        else $error("control register reset value wrong");

    AST_WRITE_READ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (cfg_wr_i && hit_ctl) ##1 (cfg_rd_i && hit_ctl && !cfg_wr_i)
            |=> (cfg_rdata_o == $past(cfg_wdata_i, 2)))
        else $error("written control byte not read back");

    AST_ATTEN_SEL: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (cfg_wr_i && hit_ctl) |=> ##1 (rx_atten_sel_o == $past(cfg_wdata_i[5:4], 2)))
        else $error("attenuation select does not follow write");

    // port and power checks; a refused or absent request must leave state alone, an unmapped read returns zero, a sleep request is taken
    AST_CTL_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !(cfg_wr_i && hit_ctl)
            |=> $stable(ctl_reg))
        else $error("control register moved without a write to it");

    AST_RDATA_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !cfg_rd_i
            |=> $stable(cfg_rdata_o))
        else $error("read data moved without a read");

    AST_UNMAPPED_RD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (cfg_rd_i && !hit_ctl && !hit_trim_a && !hit_trim_b)
            |=> (cfg_rdata_o == 8'h00))
        else $error("unmapped read did not return zero");

    AST_SLEEP_TAKEN: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!asleep_o && sleep_enter_i)
            |=> asleep_o)
        else $error("sleep request not taken");

    AST_ASLEEP_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (asleep_o && !wake_i)
            |=> asleep_o)
        else $error("sleep left without a wake");

    AST_TRIM_HOLD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !(asleep_o && wake_i)
            |=> (analog_trim_a_o == $past(analog_trim_a_o)
                && analog_trim_b_o == $past(analog_trim_b_o)))
        else $error("trims moved outside a wake from sleep");

endmodule

`default_nettype wire

// ===== rft_host.sv
// host side model driving the configuration port and the power pulses
`timescale 1ns/1ps
`default_nettype none
`include "rft_cfg.svh"

module rft_host (
    input wire logic ref_clk_i,                  // 10 MHz clock
    output rft_pkg::rft_addr_t cfg_addr_o,       // config address
    output logic cfg_wr_o,                       // write strobe
    output rft_pkg::rft_byte_t cfg_wdata_o,      // write data
    output logic cfg_rd_o,                       // read strobe
    input wire rft_pkg::rft_byte_t cfg_rdata_i,  // read data
    output logic sleep_enter_o,                  // sleep pulse
    output logic wake_o,                         // wake pulse
    input wire logic asleep_i                    // sleep state, watched mid-nap
);
    import rft_pkg::*;

    // idle port at time zero
    initial begin
        cfg_addr_o = 6'h00;
        cfg_wr_o = 1'b0;
        cfg_wdata_o = 8'h00;
        cfg_rd_o = 1'b0;
        sleep_enter_o = 1'b0;
        wake_o = 1'b0;
    end

    // one write; address and data flip after the strobe so stale values never match
    task automatic wr(input rft_addr_t a, input rft_byte_t d);
        @(posedge ref_clk_i);
        cfg_addr_o <= a;
        cfg_wdata_o <= d;
        cfg_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        cfg_wr_o <= 1'b0;
        cfg_addr_o <= ~a;
        cfg_wdata_o <= ~d;
    endtask

    // one read; data is taken once it has settled, it holds until the next read
    task automatic rd(input rft_addr_t a, output rft_byte_t d);
        @(posedge ref_clk_i);
        cfg_addr_o <= a;
        cfg_rd_o <= 1'b1;
        @(posedge ref_clk_i);
        cfg_rd_o <= 1'b0;
        cfg_addr_o <= ~a;
        @(posedge ref_clk_i);
        #1;
        d = cfg_rdata_i;
    endtask

    // sleep then wake; a narrow filter at wake needs the keep bit set first
    task automatic nap(input logic narrow, output logic mid);
        rft_byte_t d;
        if (narrow) begin
            rd(`RFT_ADDR_CTL, d);
            wr(`RFT_ADDR_CTL, d | 8'h40);
        end
        @(posedge ref_clk_i);
        sleep_enter_o <= 1'b1;
        @(posedge ref_clk_i);
        sleep_enter_o <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        mid = asleep_i;
        @(posedge ref_clk_i);
        wake_o <= 1'b1;
        @(posedge ref_clk_i);
        wake_o <= 1'b0;
    endtask

    // write then read back to back, the read strobe follows the write at once
    task automatic wr_rd(input rft_addr_t a, input rft_byte_t w, output rft_byte_t d);
        @(posedge ref_clk_i);
        cfg_addr_o <= a;
        cfg_wdata_o <= w;
        cfg_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        cfg_wr_o <= 1'b0;
        cfg_wdata_o <= ~w;
        cfg_rd_o <= 1'b1;
        @(posedge ref_clk_i);
        cfg_rd_o <= 1'b0;
        cfg_addr_o <= ~a;
        @(posedge ref_clk_i);
        #1;
        d = cfg_rdata_i;
    endtask

    // wake pulse while already awake; the design has to ignore it
    task automatic stray_wake;
        @(posedge ref_clk_i);
        wake_o <= 1'b1;
        @(posedge ref_clk_i);
        wake_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== rx_fifo_threshold_config_tb_top.sv
// self-checking bench for the receive fifo threshold register
`timescale 1ns/1ps
`default_nettype none
`include "rft_cfg.svh"

module rx_fifo_threshold_config_tb_top;
    import rft_pkg::*;
    localparam rft_byte_t TA = 8'h5A; // arbitrary readback value
    localparam rft_byte_t TB = 8'hA5; // arbitrary readback value
    logic ref_clk_i, resetn_i, cfg_wr, cfg_rd, sleep_enter, wake, asleep_o, rx_fill_over_o;
    rft_addr_t cfg_addr;
    rft_byte_t cfg_wdata, cfg_rdata, analog_trim_a_o, analog_trim_b_o;
    logic [1:0] rx_atten_sel_o;
    logic [4:0] rx_atten_db_o;
    rft_count_t rx_fill_count_i;
    int bad_count;
    int check_count;

    rft_top #(.TRIM_A_RESET(TA), .TRIM_B_RESET(TB)) u_dut (.ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i), .cfg_addr_i(cfg_addr), .cfg_wr_i(cfg_wr),
        .cfg_wdata_i(cfg_wdata), .cfg_rd_i(cfg_rd), .cfg_rdata_o(cfg_rdata),
        .sleep_enter_i(sleep_enter), .wake_i(wake), .asleep_o(asleep_o),
        .analog_trim_a_o(analog_trim_a_o), .analog_trim_b_o(analog_trim_b_o),
        .rx_atten_sel_o(rx_atten_sel_o), .rx_atten_db_o(rx_atten_db_o),
        .rx_fill_count_i(rx_fill_count_i), .rx_fill_over_o(rx_fill_over_o));
    rft_host u_host (.ref_clk_i(ref_clk_i), .cfg_addr_o(cfg_addr), .cfg_wr_o(cfg_wr),
        .cfg_wdata_o(cfg_wdata), .cfg_rd_o(cfg_rd), .cfg_rdata_i(cfg_rdata),
        .sleep_enter_o(sleep_enter), .wake_o(wake), .asleep_i(asleep_o));

    // 100 ns clock
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // case inequality so an unknown never passes
    task automatic chk(input string n, input rft_byte_t e, input rft_byte_t g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // byte count at which the flag must be high
    function automatic rft_byte_t thr(input logic [3:0] l);
        return {2'b00, l, 2'b00} + 8'h04;
    endfunction

    // trim byte expected after a wake, by keep bit and trim register
    function automatic rft_byte_t trim_exp(input logic keep, input logic b);
        return keep ? (b ? 8'h81 : 8'h35) : (b ? 8'h88 : 8'h31);
    endfunction

    task automatic complete_run;
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // reset checks, then random settings with boundary counts around each level
    initial begin
        rft_byte_t v, d;
        logic narrow, m;
        rft_count_t c;
        bad_count = 0;
        check_count = 0;
        resetn_i = 1'b0;
        rx_fill_count_i = 7'h00;
        void'($urandom(32'h1F05));
        repeat (10) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        u_host.rd(`RFT_ADDR_CTL, d);
        chk("ctl reset", 8'h07, d);
        u_host.rd(`RFT_ADDR_TRIM_B, d);
        chk("trim b read", TB, d);
        u_host.rd(6'h10, d);
        chk("unmapped read", 8'h00, d);
        for (int i = 0; i < 24; i++) begin
            v = (i == 0) ? 8'h30 : (i == 1) ? 8'hCF : 8'($urandom);
            narrow = (i < 2) ? i[0] : 1'($urandom);
            u_host.wr_rd(`RFT_ADDR_CTL, v, d);
            chk("ctl wr rd", v, d);
            u_host.wr(6'h04, ~v); // misdirected write must leave the register alone
            u_host.rd(`RFT_ADDR_CTL, d);
            chk("ctl rw", v, d);
            chk("atten sel", {6'h00, v[5:4]}, {6'h00, rx_atten_sel_o});
            chk("atten db", 8'(v[5:4]) * 8'h06, {3'h0, rx_atten_db_o});
            for (int k = 0; k < 3; k++) begin
                c = (k == 2) ? 7'($urandom_range(64)) : 7'(thr(v[3:0]) - 8'(1 - k));
                @(posedge ref_clk_i);
                rx_fill_count_i <= c;
                repeat (2) @(posedge ref_clk_i);
                #1;
                chk("fill over", {7'h00, 8'(c) >= thr(v[3:0])}, {7'h00, rx_fill_over_o});
            end
            u_host.nap(narrow, m);
            chk("asleep mid", 8'h01, {7'h00, m});
            @(posedge ref_clk_i);
            #1;
            chk("asleep", 8'h00, {7'h00, asleep_o});
            chk("trim a", trim_exp(v[6] | narrow, 1'b0), analog_trim_a_o);
            chk("trim b", trim_exp(v[6] | narrow, 1'b1), analog_trim_b_o);
            u_host.rd(`RFT_ADDR_TRIM_A, d);
            chk("trim a read", TA, d);
            // keep bit flipped, then a wake while awake: the trims must not move
            u_host.wr(`RFT_ADDR_CTL, {v[7], ~(v[6] | narrow), v[5:0]});
            u_host.stray_wake();
            @(posedge ref_clk_i);
            #1;
            chk("trim a hold", trim_exp(v[6] | narrow, 1'b0), analog_trim_a_o);
            chk("trim b hold", trim_exp(v[6] | narrow, 1'b1), analog_trim_b_o);
        end
        // second reset in mid-run, with a written value and wake trims in place
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        #1;
        chk("trim a reset", TA, analog_trim_a_o);
        chk("trim b reset", TB, analog_trim_b_o);
        u_host.rd(`RFT_ADDR_CTL, d);
        chk("ctl reset again", 8'h07, d);
        complete_run();
    end
endmodule

`default_nettype wire
